// *** rtl/result_regs.sv ***
// Purpose: Read-only bank of charge current, input voltage and battery voltage results.
// Assumes: Converter updates and register reads come from logic on clk_sys.
// Notes: Read data valid two cycles after the read strobe; writes do not exist.
`timescale 1ns/1ps
`include "result_regs_defs.svh"
module result_regs (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_b,
  input  wire logic                           reg_reset,
  input  wire logic                           watchdog_expired,
  input  wire result_regs_pkg::result_update_t update,
  input  wire result_regs_pkg::reg_read_t      rd_req,
  output logic      [7:0]                     rd_data,
  output logic                                rd_valid,
  output logic                                rd_hit
);
  logic [1:0]  rd_idx;
  logic        rd_hi;
  logic        rd_map;
  logic [15:0] word;
  logic        pend_r;
  logic        pend_hi_r;
  logic        pend_map_r;
  logic        pend_chg_r;
  logic [15:0] upd_value;
  logic [2:0]  rd_dec;

  // Offset decode, shared by the read path and checks
  function automatic logic [2:0] decode(input logic [7:0] a);
    case (a)
      `CHG_CUR_HIGH_OFS:  decode = {1'b1, 2'd0};
      `CHG_CUR_LOW_OFS:   decode = {1'b1, 2'd0};
      `IN_VOLT_HIGH_OFS:  decode = {1'b1, 2'd1};
      `IN_VOLT_LOW_OFS:   decode = {1'b1, 2'd1};
      `BAT_VOLT_HIGH_OFS: decode = {1'b1, 2'd2};
      `BAT_VOLT_LOW_OFS:  decode = {1'b1, 2'd2};
      default:            decode = 3'h0;
    endcase
  endfunction : decode

  always_comb begin
    rd_dec = decode(rd_req.addr);
    rd_map = rd_dec[2];
    rd_idx = rd_dec[1:0];
    // High bytes sit at odd offsets here
    rd_hi  = rd_req.addr[0];
  end

  // Charge current is unsigned 15-bit; top bit forced clear
  always_comb begin
    upd_value = update.value;
    if (update.src == result_regs_pkg::SRC_CHG_CUR) begin
      upd_value[`CHG_CUR_RSVD_BIT] = 1'b0;
    end
  end

  // Watchdog expiry deliberately not wired to clear
  result_store #(
    .DEPTH (`RESULT_COUNT)
  ) u_store (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .clear   (reg_reset),
    .wr_en   (update.valid),
    .wr_idx  (update.src),
    .wr_data (upd_value),
    .rd_idx  (rd_idx),
    .rd_data (word)
  );

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pend_r     <= 1'b0;
      pend_hi_r  <= 1'b0;
      pend_map_r <= 1'b0;
      pend_chg_r <= 1'b0;
    end else begin
      pend_r     <= rd_req.rd;
      pend_hi_r  <= rd_hi;
      pend_map_r <= rd_map;
      pend_chg_r <= rd_idx == 2'd0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
      rd_hit   <= 1'b0;
    end else begin
      rd_valid <= pend_r;
      rd_hit   <= pend_r && pend_map_r;
      if (!pend_r || !pend_map_r || reg_reset) begin
        rd_data <= 8'h00;
      end else if (pend_hi_r) begin
        // Upper byte: 256 up to 16384 in bits 6:0, sign or zero in bit 7
        rd_data <= pend_chg_r ? {1'b0, word[14:8]} : word[15:8];
      end else begin
        rd_data <= word[7:0];
      end
    end
  end

  // Checks
  property p_chg_rsvd_zero;
    @(posedge clk_sys) disable iff (!rst_b)
      (rd_req.rd && rd_req.addr == `CHG_CUR_HIGH_OFS) |-> ##2 (rd_valid && !rd_data[7]);
  endproperty
  a_chg_rsvd_zero: assert property (p_chg_rsvd_zero) else $error("charge high bit 7 not zero");

  property p_read_latency;
    @(posedge clk_sys) disable iff (!rst_b)
      rd_req.rd |-> ##2 rd_valid;
  endproperty
  a_read_latency: assert property (p_read_latency) else $error("read answer late");

  property p_reset_clears;
    @(posedge clk_sys) disable iff (!rst_b)
      reg_reset ##1 (!reg_reset && !update.valid) [*2] |-> (rd_data == 8'h00);
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("register reset did not clear");

  property p_in_volt_low;
    @(posedge clk_sys) disable iff (!rst_b)
      (update.valid && update.src == result_regs_pkg::SRC_IN_VOLT && !reg_reset)
      ##1 (rd_req.rd && rd_req.addr == `IN_VOLT_LOW_OFS && !update.valid && !reg_reset)
      ##1 (!update.valid && !reg_reset)
      |-> ##1 (rd_data == $past(update.value[7:0], 3));
  endproperty
  a_in_volt_low: assert property (p_in_volt_low) else $error("input low byte wrong");

  property p_bat_high;
    @(posedge clk_sys) disable iff (!rst_b)
      (update.valid && update.src == result_regs_pkg::SRC_BAT_VOLT && !reg_reset)
      ##1 (rd_req.rd && rd_req.addr == `BAT_VOLT_HIGH_OFS && !update.valid && !reg_reset)
      ##1 (!update.valid && !reg_reset)
      |-> ##1 (rd_data == $past(update.value[15:8], 3));
  endproperty
  a_bat_high: assert property (p_bat_high) else $error("battery high byte wrong");

  property p_unmapped;
    @(posedge clk_sys) disable iff (!rst_b)
      (rd_req.rd && !rd_map) |-> ##2 (rd_valid && !rd_hit && rd_data == 8'h00);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_watchdog_keeps;
    @(posedge clk_sys) disable iff (!rst_b)
      (watchdog_expired && !reg_reset && !update.valid && rd_req.rd && rd_map)
      |-> ##2 rd_hit;
  endproperty
  a_watchdog_keeps: assert property (p_watchdog_keeps) else $error("watchdog disturbed read");

  property p_chg_low;
    @(posedge clk_sys) disable iff (!rst_b)
      (update.valid && update.src == result_regs_pkg::SRC_CHG_CUR && !reg_reset)
      ##1 (rd_req.rd && rd_req.addr == `CHG_CUR_LOW_OFS && !update.valid && !reg_reset)
      ##1 (!update.valid && !reg_reset)
      |-> ##1 (rd_data == $past(update.value[7:0], 3));
  endproperty
  a_chg_low: assert property (p_chg_low) else $error("charge low byte wrong");

  property p_chg_high;
    @(posedge clk_sys) disable iff (!rst_b)
      (update.valid && update.src == result_regs_pkg::SRC_CHG_CUR && !reg_reset)
      ##1 (rd_req.rd && rd_req.addr == `CHG_CUR_HIGH_OFS && !update.valid && !reg_reset)
      ##1 (!update.valid && !reg_reset)
      |-> ##1 (rd_data == {1'b0, $past(update.value[14:8], 3)});
  endproperty
  a_chg_high: assert property (p_chg_high) else $error("charge high byte wrong");

  property p_in_volt_high;
    @(posedge clk_sys) disable iff (!rst_b)
      (update.valid && update.src == result_regs_pkg::SRC_IN_VOLT && !reg_reset)
      ##1 (rd_req.rd && rd_req.addr == `IN_VOLT_HIGH_OFS && !update.valid && !reg_reset)
      ##1 (!update.valid && !reg_reset)
      |-> ##1 (rd_data == $past(update.value[15:8], 3));
  endproperty
  a_in_volt_high: assert property (p_in_volt_high) else $error("input high byte wrong");

  property p_bat_low;
    @(posedge clk_sys) disable iff (!rst_b)
      (update.valid && update.src == result_regs_pkg::SRC_BAT_VOLT && !reg_reset)
      ##1 (rd_req.rd && rd_req.addr == `BAT_VOLT_LOW_OFS && !update.valid && !reg_reset)
      ##1 (!update.valid && !reg_reset)
      |-> ##1 (rd_data == $past(update.value[7:0], 3));
  endproperty
  a_bat_low: assert property (p_bat_low) else $error("battery low byte wrong");

  // Clear must beat an update landing on the same edge
  property p_reset_wins;
    @(posedge clk_sys) disable iff (!rst_b)
      (reg_reset && update.valid)
      ##1 (!update.valid && !reg_reset)
      ##1 (rd_req.rd && rd_map && !update.valid && !reg_reset)
      ##1 (!update.valid && !reg_reset)
      |-> ##1 (rd_data == 8'h00);
  endproperty
  a_reset_wins: assert property (p_reset_wins) else $error("update beat register reset");

  property p_reset_answer;
    @(posedge clk_sys) disable iff (!rst_b)
      reg_reset |=> (rd_data == 8'h00);
  endproperty
  a_reset_answer: assert property (p_reset_answer) else $error("read data not cleared by register reset");

  property p_idle_zero;
    @(posedge clk_sys) disable iff (!rst_b)
      !rd_valid |-> (rd_data == 8'h00);
  endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero while idle");

  property p_valid_origin;
    @(posedge clk_sys) disable iff (!rst_b)
      rd_valid |-> $past(rd_req.rd, 2);
  endproperty
  a_valid_origin: assert property (p_valid_origin) else $error("answer without a read");

  property p_hit_needs_valid;
    @(posedge clk_sys) disable iff (!rst_b)
      rd_hit |-> rd_valid;
  endproperty
  a_hit_needs_valid: assert property (p_hit_needs_valid) else $error("hit without answer");

  c_read_chg: cover property (@(posedge clk_sys) disable iff (!rst_b)
    rd_req.rd && rd_req.addr == `CHG_CUR_HIGH_OFS);
  c_read_bat: cover property (@(posedge clk_sys) disable iff (!rst_b)
    rd_req.rd && rd_req.addr == `BAT_VOLT_LOW_OFS);
  c_reset_cmd: cover property (@(posedge clk_sys) disable iff (!rst_b) reg_reset);
  c_read_in_volt: cover property (@(posedge clk_sys) disable iff (!rst_b)
    rd_req.rd && rd_req.addr == `IN_VOLT_HIGH_OFS);
  c_reset_on_update: cover property (@(posedge clk_sys) disable iff (!rst_b) reg_reset && update.valid);
endmodule : result_regs

// *** include/result_regs_defs.svh ***
// Purpose: Constants for the measurement result register bank.
// Assumes: 8-bit registers on the device register port.
// Notes: Offsets are the printed register addresses.
// Operation
// - Charge current bits 14..8 read in bits 6:0 at 19h, 256 mA up to 16384 mA.
// - Bit 7 of 19h always reads zero, so charge current is a 15-bit non-negative value.
// - Charge current bits 7..0 read at 1Ah, 1 mA up to 128 mA.
// - Input voltage bits 15..8 read at 1Bh, 256 mV up to 16384 mV in bits 0..6.
// - Input and battery voltages are 16-bit two's complement with the sign in bit 7 of the upper byte.
// - Input voltage bits 7..0 read at 1Ch, 1 mV up to 128 mV.
// - Battery voltage bits 15..8 read at 1Dh, 256 mV up to 16384 mV in bits 0..6.
// - Battery voltage bits 7..0 read at 1Eh.
// - All result registers are read-only, reset to 00h, cleared by register reset, kept on watchdog expiry.
`ifndef RESULT_REGS_DEFS_SVH
`define RESULT_REGS_DEFS_SVH
`define CHG_CUR_HIGH_OFS   8'h19
`define CHG_CUR_LOW_OFS    8'h1A
`define IN_VOLT_HIGH_OFS   8'h1B
`define IN_VOLT_LOW_OFS    8'h1C
`define BAT_VOLT_HIGH_OFS  8'h1D
`define BAT_VOLT_LOW_OFS   8'h1E
`define RESULT_RESET_VAL   16'h0000
`define CHG_CUR_RSVD_BIT   15
`define RESULT_COUNT       3
`endif

// *** include/result_regs_pkg.sv ***
// Purpose: Types for the measurement result register bank.
// Assumes: Nothing beyond the constants header.
// Notes: One struct carries a converter update.
package result_regs_pkg;
  typedef enum logic [1:0] {
    SRC_CHG_CUR,
    SRC_IN_VOLT,
    SRC_BAT_VOLT
  } result_src_t;

  typedef struct packed {
    logic        valid;
    result_src_t src;
    logic [15:0] value;
  } result_update_t;

  typedef struct packed {
    logic       rd;
    logic [7:0] addr;
  } reg_read_t;
endpackage : result_regs_pkg

// *** rtl/result_store.sv ***
// Purpose: Small store of whole 16-bit results, one word per source.
// Assumes: Single writer, single reader, same clock.
// Notes: Read data come out of a register; clear wipes every word.
`timescale 1ns/1ps
`include "result_regs_defs.svh"
module result_store #(
  parameter int DEPTH = 3
) (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic                     clear,
  input  wire logic                     wr_en,
  input  wire logic [1:0]               wr_idx,
  input  wire logic [15:0]              wr_data,
  input  wire logic [1:0]               rd_idx,
  output logic      [15:0]              rd_data
);
  logic [15:0] mem_r [DEPTH];

  // Index ports are two bits wide, so four words at most
  if (DEPTH < 1 || DEPTH > 4) begin : g_depth_check
    $error("result_store: DEPTH must be 1..4");
  end

  // Whole word written at once so both bytes change together
  for (genvar i = 0; i < DEPTH; i++) begin : g_word
    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        mem_r[i] <= `RESULT_RESET_VAL;
      end else if (clear) begin
        mem_r[i] <= `RESULT_RESET_VAL;
      end else if (wr_en && wr_idx == 2'(i)) begin
        mem_r[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= `RESULT_RESET_VAL;
    end else if (clear) begin
      rd_data <= `RESULT_RESET_VAL;
    end else if (32'(rd_idx) < DEPTH) begin
      rd_data <= mem_r[rd_idx];
    end else begin
      rd_data <= `RESULT_RESET_VAL;
    end
  end
endmodule : result_store

// *** verification/host_model.sv ***
// Purpose: Host side model that issues result register reads.
// Assumes: Fixed two-cycle read answer.
// Notes: Idle address shows the inverse of the last one, never a stale match.
`timescale 1ns/1ps
module host_model (
  input  wire logic                  clk_sys,
  output result_regs_pkg::reg_read_t rd_req,
  input  wire logic [7:0]            rd_data,
  input  wire logic                  rd_valid,
  input  wire logic                  rd_hit
);
  initial rd_req = '0;

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v, output logic h);
    @(posedge clk_sys) #10;
    rd_req = {1'b1, a};
    @(posedge clk_sys) #10;
    rd_req = {1'b0, ~a};
    // Answer stands for this one cycle only
    @(posedge clk_sys) #10;
    {v, h, d} = {rd_valid, rd_hit, rd_data};
  endtask : rd
endmodule : host_model

// *** verification/tb.sv ***
// Purpose: Self-checking bench for the result register bank.
// Assumes: Reads answered on the edge after the taking edge.
// Notes: Expected bytes worked out from the written 16-bit words.
`timescale 1ns/1ps
module tb;
  logic                            clk_sys;
  logic                            rst_b;
  logic                            reg_reset;
  logic                            watchdog_expired;
  logic                            rd_valid;
  logic                            rd_hit;
  logic [7:0]                      rd_data;
  logic [7:0]                      d;
  logic                            v;
  logic                            h;
  result_regs_pkg::result_update_t update;
  result_regs_pkg::reg_read_t      rd_req;
  int                              n_fail = 0;
  int                              cmp_count = 0;
  int                              cyc = 0;

  result_regs dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_reset(reg_reset),
    .watchdog_expired(watchdog_expired), .update(update), .rd_req(rd_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .rd_hit(rd_hit));
  host_model host (.clk_sys(clk_sys), .rd_req(rd_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .rd_hit(rd_hit));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Whole run needs well under 300 cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      $display("ERROR cycle_limit expected %0d seen %0d", 1000, cyc);
      complete_run();
    end
  end

  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rdc(logic [7:0] a, logic [7:0] e, logic eh);
    host.rd(a, d, v, h);
    chk("rd_valid", {7'h00, v}, 8'h01);
    chk("rd_hit", {7'h00, h}, {7'h00, eh});
    chk("rd_data", d, e);
  endtask : rdc

  task automatic upd(result_regs_pkg::result_src_t s, logic [15:0] val);
    @(posedge clk_sys) #10;
    update = {1'b1, s, val};
    @(posedge clk_sys) #10;
    update = '0;
  endtask : upd

  task automatic pulse_reset;
    @(posedge clk_sys) #10;
    reg_reset = 1'b1;
    @(posedge clk_sys) #10;
    reg_reset = 1'b0;
  endtask : pulse_reset

  // Read taken on the edge right after the update lands
  task automatic upd_rd(result_regs_pkg::result_src_t s, logic [15:0] val, logic [7:0] a, logic [7:0] e);
    fork
      upd(s, val);
      begin
        @(posedge clk_sys);
        rdc(a, e, 1'b1);
      end
    join
  endtask : upd_rd

  task complete_run;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run

  initial begin
    rst_b = 1'b0;
    reg_reset = 1'b0;
    watchdog_expired = 1'b0;
    update = '0;
    repeat (10) @(posedge clk_sys);
    #10 rst_b = 1'b1;
    for (int i = 0; i < 6; i++) rdc(8'h19 + i[7:0], 8'h00, 1'b1);
    $display("test reset_values done");
    upd(result_regs_pkg::SRC_CHG_CUR, 16'hFFFF);
    rdc(8'h19, 8'h7F, 1'b1);
    rdc(8'h1A, 8'hFF, 1'b1);
    upd(result_regs_pkg::SRC_IN_VOLT, 16'h8123);
    rdc(8'h1B, 8'h81, 1'b1);
    rdc(8'h1C, 8'h23, 1'b1);
    upd(result_regs_pkg::SRC_BAT_VOLT, 16'hA5C3);
    rdc(8'h1D, 8'hA5, 1'b1);
    rdc(8'h1E, 8'hC3, 1'b1);
    $display("test byte_mapping done");
    rdc(8'h18, 8'h00, 1'b0);
    rdc(8'h1F, 8'h00, 1'b0);
    upd(result_regs_pkg::SRC_BAT_VOLT, 16'h7E01);
    rdc(8'h1E, 8'h01, 1'b1);
    rdc(8'h1D, 8'h7E, 1'b1);
    $display("test unmapped_and_pairing done");
    // Expiry held across the reads so a_watchdog_keeps sees it
    @(posedge clk_sys) #10;
    watchdog_expired = 1'b1;
    rdc(8'h1B, 8'h81, 1'b1);
    rdc(8'h1A, 8'hFF, 1'b1);
    watchdog_expired = 1'b0;
    pulse_reset();
    for (int i = 0; i < 6; i++) rdc(8'h19 + i[7:0], 8'h00, 1'b1);
    $display("test watchdog_and_reset done");
    upd_rd(result_regs_pkg::SRC_CHG_CUR, 16'hD2B4, 8'h19, 8'h52);
    upd_rd(result_regs_pkg::SRC_CHG_CUR, 16'hF0B7, 8'h1A, 8'hB7);
    upd_rd(result_regs_pkg::SRC_IN_VOLT, 16'hF00D, 8'h1B, 8'hF0);
    upd_rd(result_regs_pkg::SRC_IN_VOLT, 16'h4D2E, 8'h1C, 8'h2E);
    upd_rd(result_regs_pkg::SRC_BAT_VOLT, 16'h9C5A, 8'h1D, 8'h9C);
    upd_rd(result_regs_pkg::SRC_BAT_VOLT, 16'h36E1, 8'h1E, 8'hE1);
    $display("test update_then_read done");
    fork
      upd(result_regs_pkg::SRC_CHG_CUR, 16'h1357);
      pulse_reset();
    join
    rdc(8'h1A, 8'h00, 1'b1);
    rdc(8'h19, 8'h00, 1'b1);
    $display("test reset_beats_update done");
    complete_run();
  end
endmodule : tb
